// *** include/msi_pkg.sv ***
// package: register map, field layout, timing and bus carriers of the motion sensor irq block
`default_nettype none
package msi_pkg;
    // register indices; the bus byte address is four times the index
    localparam logic [6:0] IDX_FRAME_FLAG = 7'h36;
    localparam logic [6:0] IDX_PIN_CFG = 7'h37;
    localparam logic [6:0] IDX_IRQ_EN = 7'h38;
    localparam logic [6:0] IDX_IRQ_FLAGS = 7'h3A;
    localparam logic [6:0] IDX_ACC_XH = 7'h3B;
    localparam logic [6:0] IDX_ACC_XL = 7'h3C;
    localparam logic [6:0] IDX_ACC_YH = 7'h3D;
    localparam logic [6:0] IDX_ACC_YL = 7'h3E;
    localparam logic [6:0] IDX_ACC_ZH = 7'h3F;
    localparam logic [6:0] IDX_ACC_ZL = 7'h40;
    localparam logic [6:0] IDX_TEMP_H = 7'h41;
    localparam logic [6:0] IDX_TEMP_L = 7'h42;
    localparam logic [6:0] IDX_WAKE_THR = 7'h1F;
    localparam logic [6:0] IDX_WAKE_CTRL = 7'h69;
    // pin configuration fields
    localparam int CFG_POL = 7;
    localparam int CFG_OD = 6;
    localparam int CFG_LATCH = 5;
    localparam int CFG_RDCLR = 4;
    localparam int CFG_FSPOL = 3;
    localparam int CFG_FSEN = 2;
    localparam int CFG_ROUTE = 0;
    // enable, flag and wake control fields
    localparam int FLAG_FRAME = 7;
    localparam int WAKE_HI = 7;
    localparam int WAKE_LO = 5;
    localparam int EN_OFLOW = 4;
    localparam int EN_DRDY = 0;
    localparam int CTRL_EN = 7;
    localparam int CTRL_MODE = 6;
    localparam logic [2:0] WAKE_ON = 3'h7;
    // writable bits of each register and values after reset
    localparam logic [7:0] PIN_CFG_WMASK = 8'hFD;
    localparam logic [7:0] IRQ_EN_WMASK = 8'hF1;
    localparam logic [7:0] CTRL_WMASK = 8'hC0;
    localparam logic [7:0] REG_RST = 8'h00;
    // one threshold count is 4 mg; at +-2g a sample count is 1/16384 g, about 64 counts
    localparam logic [2:0] WAKE_SHIFT_BASE = 3'h6;
    // pulse width of the non-latched pin
    localparam int PULSE_US = 50;
    localparam int CLK_MHZ = 250;
    localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
    localparam int PCW = $clog2(PULSE_CYC + 1);
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_RESP = 2'b10} msi_bus_e;
    typedef struct packed {
        logic [11:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [11:0] araddr;
        logic arvalid;
        logic rready;
    } msi_axi_req_s;
    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } msi_axi_rsp_s;
    typedef struct packed {
        logic out;
        logic oe;
    } msi_pin_s;
endpackage : msi_pkg
`default_nettype wire

// *** rtl/msi_wake_det.sv ***
// motion wake detector: compares each accel sample with a reference against a threshold
`timescale 1ns/1ps
`default_nettype none
module msi_wake_det (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // sample stream, {x, y, z}
    input wire logic smp_valid_i,
    input wire logic [47:0] smp_i,
    // configuration
    input wire logic det_en_i,
    input wire logic motion_compare_mode_i,
    input wire logic [7:0] motion_wake_threshold_i,
    input wire logic [1:0] accel_fs_i,
    // one-cycle wake pulse
    output logic wake_o
);
    typedef struct packed {
        logic have_ref;
        logic [47:0] ref_smp;
        logic wake;
    } msi_det_s;
    msi_det_s r_reg;
    msi_det_s r_next;

    // scaled distance against threshold; the shift keeps 4 mg per count at every range
    function automatic logic over_thr(input logic [15:0] a, input logic [15:0] b,
                                      input logic [1:0] fs, input logic [7:0] thr);
        logic [16:0] sa;
        logic [16:0] sb;
        logic [16:0] d;
        sa = {a[15], a};
        sb = {b[15], b};
        d = ($signed(sa) > $signed(sb)) ? (sa - sb) : (sb - sa);
        d = d >> (msi_pkg::WAKE_SHIFT_BASE - {1'b0, fs});
        return d > {9'h000, thr};
    endfunction : over_thr

    // reference is the first sample after enable, or the previous one in mode 1
    always_comb begin
        r_next = r_reg;
        r_next.wake = 1'b0;
        if (!det_en_i) begin
            r_next.have_ref = 1'b0;
        end else if (smp_valid_i) begin
            if (r_reg.have_ref) begin
                r_next.wake = over_thr(smp_i[47:32], r_reg.ref_smp[47:32], accel_fs_i,
                                       motion_wake_threshold_i)
                            | over_thr(smp_i[31:16], r_reg.ref_smp[31:16], accel_fs_i,
                                       motion_wake_threshold_i)
                            | over_thr(smp_i[15:0], r_reg.ref_smp[15:0], accel_fs_i,
                                       motion_wake_threshold_i);
            end
            if (!r_reg.have_ref || motion_compare_mode_i) begin
                r_next.ref_smp = smp_i;
            end
            r_next.have_ref = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign wake_o = r_reg.wake;
endmodule : msi_wake_det
`default_nettype wire

// *** rtl/msi_top.sv ***
// motion sensor irq flags, pin routing and result registers behind an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - frame-sync event sets flag, read clears it
// - polarity bit makes both pins active low
// - drive bit selects open drain or push-pull
// - latched pin holds until status cleared
// - unlatched pin gives a 50 us pulse
// - read-clear bit: any read clears status
// - frame-sync polarity bit selects active level
// - frame-sync enable: edge to active raises interrupt
// - routing bit moves non data-ready to secondary
// - wake enable field 111 enables, 000 disables
// - overflow enable bit gates overflow interrupt
// - data-ready enable bit gates data-ready interrupt
// - wake reports 111 in status, read clears
// - overflow sets status bit 4, read clears
// - data ready sets status bit 0, read clears
// - accel axes read-only, high byte first
// - temperature read-only, high then low byte
// - wake threshold 8 bits, 4 mg per count
// - wake compares to first or previous sample
module msi_top #(
    parameter int PULSE_CYCLES = msi_pkg::PULSE_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register bus
    input wire msi_pkg::msi_axi_req_s axi_req_i,
    output var msi_pkg::msi_axi_rsp_s axi_rsp_o,
    // sensor events and results, same clock
    input wire logic drdy_evt_i,
    input wire logic overflow_evt_i,
    input wire logic [15:0] accel_x_i,
    input wire logic [15:0] accel_y_i,
    input wire logic [15:0] accel_z_i,
    input wire logic [15:0] temp_i,
    input wire logic [1:0] accel_fs_i,
    // frame-sync pin, asynchronous
    input wire logic frame_sync_input_i,
    // interrupt pins
    output var msi_pkg::msi_pin_s primary_irq_pin_o,
    output var msi_pkg::msi_pin_s secondary_irq_pin_o
);
    typedef struct packed {
        msi_pkg::msi_axi_rsp_s axi;
        msi_pkg::msi_bus_e wr_st;
        msi_pkg::msi_bus_e rd_st;
        logic aw_got;
        logic w_got;
        logic aw_bad;
        logic [6:0] aw_idx;
        logic [7:0] wdata;
        logic wen;
        logic [7:0] pin_cfg;
        logic [7:0] irq_en;
        logic [7:0] wake_thr;
        logic [7:0] wake_ctrl;
        logic fs_flag;
        logic [2:0] wake_flags;
        logic ovf_flag;
        logic drdy_flag;
        logic fs_m;
        logic fs_s;
        logic fs_act_d;
        logic [msi_pkg::PCW-1:0] cnt0;
        logic [msi_pkg::PCW-1:0] cnt1;
        msi_pkg::msi_pin_s pin0;
        msi_pkg::msi_pin_s pin1;
    } msi_top_s;
    msi_top_s r_reg;
    msi_top_s n;

    logic aw_take;
    logic w_take;
    logic ar_take;
    logic wake_pulse;
    logic fs_act;
    logic fs_evt;
    logic wake_set;
    logic ovf_set;
    logic drdy_set;
    logic oth_set;
    logic ev0;
    logic ev1;
    logic rd_clr_fs;
    logic rd_clr_st;
    logic pend_d;
    logic pend_o;
    logic act0;
    logic act1;
    logic [6:0] ar_idx;

    // index decode shared by reads and writes
    function automatic logic is_mapped(input logic [6:0] idx);
        return (idx >= msi_pkg::IDX_FRAME_FLAG && idx <= msi_pkg::IDX_TEMP_L
                && idx != 7'h39) || idx == msi_pkg::IDX_WAKE_THR
                || idx == msi_pkg::IDX_WAKE_CTRL;
    endfunction : is_mapped

    // pin level from the active state and the pin configuration
    function automatic msi_pkg::msi_pin_s drive(input logic act, input logic [7:0] cfg);
        msi_pkg::msi_pin_s p;
        p.out = act ^ cfg[msi_pkg::CFG_POL];
        p.oe = !cfg[msi_pkg::CFG_OD] || !p.out;
        return p;
    endfunction : drive

    // read data of one register; results are passed through live, not snapshot
    function automatic logic [7:0] rd_byte(input logic [6:0] idx, input msi_top_s s);
        case (idx)
            msi_pkg::IDX_FRAME_FLAG: rd_byte = {s.fs_flag, 7'h00};
            msi_pkg::IDX_PIN_CFG: rd_byte = s.pin_cfg;
            msi_pkg::IDX_IRQ_EN: rd_byte = s.irq_en;
            msi_pkg::IDX_IRQ_FLAGS: rd_byte = {s.wake_flags, s.ovf_flag, 3'h0, s.drdy_flag};
            msi_pkg::IDX_ACC_XH: rd_byte = accel_x_i[15:8];
            msi_pkg::IDX_ACC_XL: rd_byte = accel_x_i[7:0];
            msi_pkg::IDX_ACC_YH: rd_byte = accel_y_i[15:8];
            msi_pkg::IDX_ACC_YL: rd_byte = accel_y_i[7:0];
            msi_pkg::IDX_ACC_ZH: rd_byte = accel_z_i[15:8];
            msi_pkg::IDX_ACC_ZL: rd_byte = accel_z_i[7:0];
            msi_pkg::IDX_TEMP_H: rd_byte = temp_i[15:8];
            msi_pkg::IDX_TEMP_L: rd_byte = temp_i[7:0];
            msi_pkg::IDX_WAKE_THR: rd_byte = s.wake_thr;
            msi_pkg::IDX_WAKE_CTRL: rd_byte = s.wake_ctrl;
            default: rd_byte = 8'h00;
        endcase
    endfunction : rd_byte

    // bus handshakes seen this cycle
    assign aw_take = axi_req_i.awvalid && r_reg.axi.awready;
    assign w_take = axi_req_i.wvalid && r_reg.axi.wready;
    assign ar_take = axi_req_i.arvalid && r_reg.axi.arready;
    assign ar_idx = axi_req_i.araddr[8:2];

    // motion wake comparison runs on every data-ready sample
    msi_wake_det u_wake (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .smp_valid_i(drdy_evt_i),
        .smp_i({accel_x_i, accel_y_i, accel_z_i}),
        .det_en_i(r_reg.wake_ctrl[msi_pkg::CTRL_EN]),
        .motion_compare_mode_i(r_reg.wake_ctrl[msi_pkg::CTRL_MODE]),
        .motion_wake_threshold_i(r_reg.wake_thr),
        .accel_fs_i(accel_fs_i),
        .wake_o(wake_pulse)
    );

    // next state of the whole block
    always_comb begin
        n = r_reg;
        rd_clr_fs = 1'b0;
        rd_clr_st = 1'b0;
        // address and data may arrive in either order
        if (aw_take) begin
            n.aw_got = 1'b1;
            n.aw_idx = axi_req_i.awaddr[8:2];
            n.aw_bad = |axi_req_i.awaddr[11:9];
        end
        if (w_take) begin
            n.w_got = 1'b1;
            n.wdata = axi_req_i.wdata[7:0];
            n.wen = axi_req_i.wstrb[0];
        end
        case (r_reg.wr_st)
            msi_pkg::BUS_IDLE: begin
                if (r_reg.aw_got && r_reg.w_got) begin
                    n.aw_got = 1'b0;
                    n.w_got = 1'b0;
                    n.wr_st = msi_pkg::BUS_RESP;
                    n.axi.bvalid = 1'b1;
                    n.axi.bresp = msi_pkg::RESP_OKAY;
                    if (r_reg.aw_bad || !is_mapped(r_reg.aw_idx)) begin
                        n.axi.bresp = msi_pkg::RESP_SLVERR;
                    end else if (r_reg.wen) begin
                        // flag and result registers take no write
                        case (r_reg.aw_idx)
                            msi_pkg::IDX_PIN_CFG: n.pin_cfg = r_reg.wdata & msi_pkg::PIN_CFG_WMASK;
                            msi_pkg::IDX_IRQ_EN: n.irq_en = r_reg.wdata & msi_pkg::IRQ_EN_WMASK;
                            msi_pkg::IDX_WAKE_THR: n.wake_thr = r_reg.wdata;
                            msi_pkg::IDX_WAKE_CTRL: n.wake_ctrl = r_reg.wdata & msi_pkg::CTRL_WMASK;
                            default: n.wdata = r_reg.wdata;
                        endcase
                    end
                end
            end
            msi_pkg::BUS_RESP: begin
                if (axi_req_i.bready) begin
                    n.axi.bvalid = 1'b0;
                    n.wr_st = msi_pkg::BUS_IDLE;
                end
            end
            default: n.wr_st = msi_pkg::BUS_IDLE;
        endcase
        n.axi.awready = (n.wr_st == msi_pkg::BUS_IDLE) && !n.aw_got;
        n.axi.wready = (n.wr_st == msi_pkg::BUS_IDLE) && !n.w_got;
        // read answers one cycle after the address is taken
        case (r_reg.rd_st)
            msi_pkg::BUS_IDLE: begin
                if (ar_take) begin
                    n.rd_st = msi_pkg::BUS_RESP;
                    n.axi.rvalid = 1'b1;
                    n.axi.rdata = {24'h000000, rd_byte(ar_idx, r_reg)};
                    n.axi.rresp = (!(|axi_req_i.araddr[11:9]) && is_mapped(ar_idx))
                                ? msi_pkg::RESP_OKAY : msi_pkg::RESP_SLVERR;
                    rd_clr_fs = ar_idx == msi_pkg::IDX_FRAME_FLAG
                             || r_reg.pin_cfg[msi_pkg::CFG_RDCLR];
                    rd_clr_st = ar_idx == msi_pkg::IDX_IRQ_FLAGS
                             || r_reg.pin_cfg[msi_pkg::CFG_RDCLR];
                end
            end
            msi_pkg::BUS_RESP: begin
                if (axi_req_i.rready) begin
                    n.axi.rvalid = 1'b0;
                    n.rd_st = msi_pkg::BUS_IDLE;
                end
            end
            default: n.rd_st = msi_pkg::BUS_IDLE;
        endcase
        n.axi.arready = n.rd_st == msi_pkg::BUS_IDLE;
        // frame-sync pin: two flops, then edge to the selected active level
        n.fs_m = frame_sync_input_i;
        n.fs_s = r_reg.fs_m;
        fs_act = r_reg.fs_s ^ r_reg.pin_cfg[msi_pkg::CFG_FSPOL];
        n.fs_act_d = fs_act;
        fs_evt = fs_act && !r_reg.fs_act_d && r_reg.pin_cfg[msi_pkg::CFG_FSEN];
        // only enabled events reach a flag
        wake_set = wake_pulse
                && r_reg.irq_en[msi_pkg::WAKE_HI:msi_pkg::WAKE_LO] == msi_pkg::WAKE_ON;
        ovf_set = overflow_evt_i && r_reg.irq_en[msi_pkg::EN_OFLOW];
        drdy_set = drdy_evt_i && r_reg.irq_en[msi_pkg::EN_DRDY];
        // clears first so that an event in the clearing cycle wins
        if (rd_clr_fs) begin
            n.fs_flag = 1'b0;
        end
        if (rd_clr_st) begin
            n.wake_flags = 3'h0;
            n.ovf_flag = 1'b0;
            n.drdy_flag = 1'b0;
        end
        if (fs_evt) begin
            n.fs_flag = 1'b1;
        end
        if (wake_set) begin
            n.wake_flags = msi_pkg::WAKE_ON;
        end
        if (ovf_set) begin
            n.ovf_flag = 1'b1;
        end
        if (drdy_set) begin
            n.drdy_flag = 1'b1;
        end
        // data ready stays on the primary pin, others follow the routing bit
        oth_set = wake_set || ovf_set || fs_evt;
        ev0 = drdy_set || (oth_set && !r_reg.pin_cfg[msi_pkg::CFG_ROUTE]);
        ev1 = oth_set && r_reg.pin_cfg[msi_pkg::CFG_ROUTE];
        // pulse timers restart on every new event
        n.cnt0 = ev0 ? msi_pkg::PCW'(PULSE_CYCLES)
               : (r_reg.cnt0 != '0) ? r_reg.cnt0 - 1'b1 : r_reg.cnt0;
        n.cnt1 = ev1 ? msi_pkg::PCW'(PULSE_CYCLES)
               : (r_reg.cnt1 != '0) ? r_reg.cnt1 - 1'b1 : r_reg.cnt1;
        // latched level follows pending flags whose enable is still set
        pend_d = n.drdy_flag && n.irq_en[msi_pkg::EN_DRDY];
        pend_o = (n.wake_flags == msi_pkg::WAKE_ON
                  && n.irq_en[msi_pkg::WAKE_HI:msi_pkg::WAKE_LO] == msi_pkg::WAKE_ON)
              || (n.ovf_flag && n.irq_en[msi_pkg::EN_OFLOW])
              || (n.fs_flag && n.pin_cfg[msi_pkg::CFG_FSEN]);
        if (n.pin_cfg[msi_pkg::CFG_LATCH]) begin
            act0 = pend_d || (pend_o && !n.pin_cfg[msi_pkg::CFG_ROUTE]);
            act1 = pend_o && n.pin_cfg[msi_pkg::CFG_ROUTE];
        end else begin
            act0 = n.cnt0 != '0;
            // a pulse left running when routing is switched off must not reach the pin
            act1 = n.cnt1 != '0 && n.pin_cfg[msi_pkg::CFG_ROUTE];
        end
        n.pin0 = drive(act0, n.pin_cfg);
        n.pin1 = drive(act1, n.pin_cfg);
    end

    // state register; pins drive their inactive push-pull level in reset
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r_reg <= '0;
            r_reg.wr_st <= msi_pkg::BUS_IDLE;
            r_reg.rd_st <= msi_pkg::BUS_IDLE;
            r_reg.pin_cfg <= msi_pkg::REG_RST;
            r_reg.irq_en <= msi_pkg::REG_RST;
            r_reg.pin0.oe <= 1'b1;
            r_reg.pin1.oe <= 1'b1;
        end else begin
            r_reg <= n;
        end
    end

    assign axi_rsp_o = r_reg.axi;
    assign primary_irq_pin_o = r_reg.pin0;
    assign secondary_irq_pin_o = r_reg.pin1;

    // checks on the block's own outputs and state
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_frame_flag_set: assert property (fs_evt |=> r_reg.fs_flag)
        else $error("frame-sync event did not set its flag");
    a_frame_flag_clr: assert property (
        ar_take && ar_idx == msi_pkg::IDX_FRAME_FLAG && !fs_evt
        |=> !r_reg.fs_flag && r_reg.axi.rvalid)
        else $error("frame-sync flag not cleared by its read");
    a_pin_drive_type: assert property (
        r_reg.pin0.oe == (!r_reg.pin_cfg[msi_pkg::CFG_OD] || !r_reg.pin0.out))
        else $error("primary pin drive type wrong");
    a_latched_level: assert property (
        r_reg.pin_cfg[msi_pkg::CFG_LATCH] && r_reg.drdy_flag && r_reg.irq_en[msi_pkg::EN_DRDY]
        |-> r_reg.pin0.out != r_reg.pin_cfg[msi_pkg::CFG_POL])
        else $error("latched primary pin not at active level");
    a_pulse_count: assert property (
        r_reg.cnt0 != '0 && !ev0 |=> r_reg.cnt0 == $past(r_reg.cnt0) - 1'b1)
        else $error("pulse timer did not count down");
    a_pulse_load: assert property (ev0 |=> r_reg.cnt0 == msi_pkg::PCW'(PULSE_CYCLES))
        else $error("pulse timer not loaded on event");
    a_read_clear_any: assert property (
        ar_take && r_reg.pin_cfg[msi_pkg::CFG_RDCLR]
        && !fs_evt && !wake_set && !ovf_set && !drdy_set
        |=> !r_reg.fs_flag && !r_reg.ovf_flag && !r_reg.drdy_flag
        && r_reg.wake_flags == 3'h0)
        else $error("read with read-clear left status set");
    a_route_unused: assert property (
        !r_reg.pin_cfg[msi_pkg::CFG_ROUTE]
        |-> r_reg.pin1.out == r_reg.pin_cfg[msi_pkg::CFG_POL])
        else $error("secondary pin active while unrouted");
    a_wake_gate: assert property (
        $rose(r_reg.wake_flags[0])
        |-> $past(r_reg.irq_en[msi_pkg::WAKE_HI:msi_pkg::WAKE_LO]) == msi_pkg::WAKE_ON)
        else $error("wake flags set while disabled");
    a_event_wins: assert property (
        ovf_set && rd_clr_st |=> r_reg.ovf_flag ##1 (r_reg.ovf_flag || $past(rd_clr_st)))
        else $error("overflow lost in clearing cycle");
    a_drdy_set: assert property (
        drdy_evt_i |=> r_reg.drdy_flag == $past(r_reg.irq_en[0]
        || (r_reg.drdy_flag && !rd_clr_st)))
        else $error("data-ready flag wrong");
    a_ro_write: assert property (
        r_reg.wr_st == msi_pkg::BUS_IDLE && r_reg.aw_got && r_reg.w_got
        && r_reg.aw_idx == msi_pkg::IDX_IRQ_FLAGS
        |=> $stable(r_reg.pin_cfg) && $stable(r_reg.irq_en))
        else $error("write to flag register changed configuration");

    c_frame_event: cover property (fs_evt ##1 r_reg.fs_flag);
    c_pulse_done: cover property (r_reg.cnt0 == 14'h0001 ##1 r_reg.cnt0 == '0);
    c_flags_read: cover property (ar_take && ar_idx == msi_pkg::IDX_IRQ_FLAGS);
    c_secondary: cover property (r_reg.pin_cfg[msi_pkg::CFG_ROUTE] && ev1);
endmodule : msi_top
`default_nettype wire

// *** dv/msi_host_pins.sv ***
// host side view of the two irq pins, pulled up on the board
`timescale 1ns/1ps
`default_nettype none
module msi_host_pins (
    // pins from the device
    input wire msi_pkg::msi_pin_s pri_i,
    input wire msi_pkg::msi_pin_s sec_i,
    // wire levels seen by the host
    output logic pri_lvl_o,
    output logic sec_lvl_o
);
    // a released pin floats to the pull-up, never holds its last value
    assign pri_lvl_o = pri_i.oe ? pri_i.out : 1'b1;
    assign sec_lvl_o = sec_i.oe ? sec_i.out : 1'b1;
endmodule : msi_host_pins
`default_nettype wire

// *** dv/msi_top_tb.sv ***
// self-checking bench for irq flags, pins and result registers
`timescale 1ns/1ps
`default_nettype none
module msi_top_tb;
    localparam logic [6:0] CF = msi_pkg::IDX_PIN_CFG;
    localparam logic [6:0] EN = msi_pkg::IDX_IRQ_EN;
    localparam logic [6:0] ST = msi_pkg::IDX_IRQ_FLAGS;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    msi_pkg::msi_axi_req_s rq = '0;
    msi_pkg::msi_axi_rsp_s rs;
    msi_pkg::msi_pin_s pp;
    msi_pkg::msi_pin_s sp;
    logic drdy = 1'b0;
    logic ovf = 1'b0;
    logic fs = 1'b1;
    logic pl;
    logic sl;
    logic [63:0] smp = 64'h123456789ABCDEF0;
    logic [1:0] fsr = 2'h0;
    logic [1:0] rsp;
    int fails = 0;
    int num_checks = 0;
    // 250 MHz
    always #2 clk_i = ~clk_i;
    msi_top #(.PULSE_CYCLES(20)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .axi_req_i(rq), .axi_rsp_o(rs), .drdy_evt_i(drdy), .overflow_evt_i(ovf),
        .accel_x_i(smp[63:48]), .accel_y_i(smp[47:32]), .accel_z_i(smp[31:16]),
        .temp_i(smp[15:0]), .accel_fs_i(fsr), .frame_sync_input_i(fs),
        .primary_irq_pin_o(pp), .secondary_irq_pin_o(sp));
    msi_host_pins host (.pri_i(pp), .sec_i(sp), .pri_lvl_o(pl), .sec_lvl_o(sl));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("Error %0t: got %h exp %h", $time, s, e);
        end
    endtask : chk
    // address and data are each released when taken; either order works
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_i);
        rq.awaddr <= {3'h0, a, 2'h0};
        rq.wdata <= {24'h0, d};
        rq.wstrb <= 4'hF;
        {rq.awvalid, rq.wvalid, rq.bready} <= 3'h7;
        do begin
            @(posedge clk_i);
            if (rs.awready) rq.awvalid <= 1'b0;
            if (rs.wready) rq.wvalid <= 1'b0;
        end while (!rs.bvalid);
        rsp = rs.bresp;
        rq.bready <= 1'b0;
    endtask : wr
    task automatic rc(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk_i);
        rq.araddr <= {3'h0, a, 2'h0};
        {rq.arvalid, rq.rready} <= 2'h3;
        do begin
            @(posedge clk_i);
            if (rs.arready) rq.arvalid <= 1'b0;
        end while (!rs.rvalid);
        chk(rs.rdata[7:0], e);
        rsp = rs.rresp;
        rq.rready <= 1'b0;
    endtask : rc
    // one-cycle event, then two edges for flag and pin to land
    task automatic ev(input bit o);
        @(posedge clk_i);
        if (o) ovf <= 1'b1;
        else drdy <= 1'b1;
        @(posedge clk_i);
        {ovf, drdy} <= 2'h0;
        repeat (2) @(posedge clk_i);
    endtask : ev
    task automatic pn(input logic p, input logic s);
        chk({6'h0, pl, sl}, {6'h0, p, s});
    endtask : pn
    task automatic t_regs;
        rc(CF, 8'h00);
        wr(CF, 8'hFF);
        rc(CF, 8'hFD);
        wr(CF, 8'h00);
        wr(7'h3B, 8'h55);
        wr(ST, 8'hFF);
        chk({6'h0, rsp}, {6'h0, msi_pkg::RESP_OKAY});
        rc(ST, 8'h00);
        rc(7'h00, 8'h00);
        chk({6'h0, rsp}, {6'h0, msi_pkg::RESP_SLVERR});
        for (int i = 0; i < 8; i++) rc(7'h3B + 7'(i), smp[63-8*i -: 8]);
        $display("regs done");
    endtask : t_regs
    task automatic t_latch;
        wr(EN, 8'h01);
        wr(CF, 8'h20);
        ev(0);
        pn(1, 0);
        rc(ST, 8'h01);
        pn(0, 0);
        wr(EN, 8'h11);
        wr(CF, 8'hA1);
        ev(1);
        pn(1, 0);
        ev(0);
        pn(0, 0);
        rc(ST, 8'h11);
        // overflow in the very cycle of the clearing read: the set must win
        fork
            rc(ST, 8'h00);
            ev(1);
        join
        rc(ST, 8'h10);
        wr(EN, 8'h00);
        ev(1);
        ev(0);
        rc(ST, 8'h00);
        $display("latch done");
    endtask : t_latch
    task automatic t_fs;
        wr(CF, 8'h2C);
        fs <= 1'b0;
        repeat (6) @(posedge clk_i);
        pn(1, 0);
        rc(7'h36, 8'h80);
        rc(7'h36, 8'h00);
        wr(CF, 8'h28);
        fs <= 1'b1;
        repeat (6) @(posedge clk_i);
        fs <= 1'b0;
        repeat (6) @(posedge clk_i);
        rc(7'h36, 8'h00);
        wr(CF, 8'h24);
        fs <= 1'b1;
        repeat (6) @(posedge clk_i);
        rc(7'h36, 8'h80);
        $display("frame-sync done");
    endtask : t_fs
    task automatic t_pulse;
        wr(CF, 8'h00);
        wr(EN, 8'h01);
        ev(0);
        pn(1, 0);
        repeat (18) @(posedge clk_i);
        pn(1, 0);
        @(posedge clk_i);
        pn(0, 0);
        wr(CF, 8'h30);
        ev(0);
        rc(EN, 8'h01);
        rc(ST, 8'h00);
        wr(CF, 8'h60);
        pn(0, 0);
        ev(0);
        pn(1, 0);
        chk({7'h0, pp.oe}, 8'h00);
        wr(7'h69, 8'h80);
        wr(EN, 8'hE0);
        smp <= '0;
        ev(0);
        smp[63:48] <= 16'h4000;
        ev(0);
        rc(ST, 8'hE1);
        rc(ST, 8'h00);
        // 512 mg threshold: 0.44 g step is below it at 2 g, 0.88 g step above it at 4 g
        wr(7'h1F, 8'h80);
        smp[63:48] <= 16'h1C00;
        ev(0);
        rc(ST, 8'h00);
        fsr <= 2'h1;
        ev(0);
        rc(ST, 8'hE0);
        // previous-sample mode: a repeated sample shows no motion
        wr(7'h69, 8'hC0);
        ev(0);
        rc(ST, 8'hE0);
        ev(0);
        rc(ST, 8'h00);
        $display("pulse done");
    endtask : t_pulse
    task automatic complete_run;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    // main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_regs();
        t_latch();
        t_fs();
        t_pulse();
        complete_run();
    end
    // watchdog: the run needs about 300 cycles
    initial begin
        #40000;
        fails++;
        complete_run();
    end
endmodule : msi_top_tb
`default_nettype wire
